// ### bench/vscd_decoder_bench.sv
// Self-checking bench of the serial command decoder
`default_nettype none
module vscd_decoder_bench
  import vscd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {int k; logic [34:0] v;} vscd_note_t;

  logic                  clock = 1'b0;
  logic                  arst_n;
  wire                   chip_select_low;
  wire                   shift_clock_in;
  wire                   serial_data_in;
  logic [3:0]            digit_select;
  logic [GLYPH_DOTS-1:0] rom_data;
  logic [7:0]            rom_code;
  logic [GLYPH_DOTS-1:0] dots;
  logic [1:0]            syms;
  logic [DIGITS-1:0]     grid;
  logic [1:0]            ports;
  logic [2:0]            duty;
  logic [2:0]            digits;
  logic                  lights;
  logic [31:0]           lfsr = 32'h6cee_8b44;
  logic [7:0]            code [16];
  logic [7:0]            cols [5];
  logic [34:0]           pat;
  vscd_note_t            notes[$];
  event                  probe;
  int                    n_fail = 0;
  int                    n_compared = 0;
  string names[8] = '{"ports", "duty", "digits", "rom_code", "dots",
                      "symbols", "grid", "lights"};

  always #5 clock = ~clock;

  vscd_host_model i_host (
    .chip_select_low(chip_select_low),
    .shift_clock_in (shift_clock_in),
    .serial_data_in (serial_data_in)
  );

  vscd_decoder i_dut (
    .clock                 (clock),
    .arst_n                (arst_n),
    .chip_select_low       (chip_select_low),
    .shift_clock_in        (shift_clock_in),
    .serial_data_in        (serial_data_in),
    .digit_select          (digit_select),
    .fixed_glyph_rom_data  (rom_data),
    .fixed_glyph_rom_code  (rom_code),
    .dot_segment_outputs   (dots),
    .symbol_segment_outputs(syms),
    .grid_outputs          (grid),
    .static_output_ports   (ports),
    .duty_field            (duty),
    .digit_count_field     (digits),
    .all_lights_on         (lights)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction

  function automatic logic [34:0] seen_of(input int k);
    case (k)
      0: return 35'(ports);
      1: return 35'(duty);
      2: return 35'(digits);
      3: return 35'(rom_code);
      4: return dots;
      5: return 35'(syms);
      6: return 35'(grid);
      default: return 35'(lights);
    endcase
  endfunction

  task automatic check(input string nm, input logic [34:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Watcher checks every pending note, oldest first, whenever a result is presented
  always @(probe) begin
    while (notes.size() > 0) begin
      vscd_note_t nt;
      nt = notes.pop_front();
      check(names[nt.k], seen_of(nt.k), nt.v);
    end
  end

  task automatic note(input int k, input logic [34:0] v);
    notes.push_back('{k, v});
  endtask

  task automatic settings(input logic [1:0] p, input logic [2:0] du, dg);
    note(0, 35'(p));
    note(1, 35'(du));
    note(2, 35'(dg));
    note(7, 35'(1'b0));
    -> probe;
  endtask

  // Every output value that reset defines
  task automatic expect_reset();
    note(4, '0);
    note(5, '0);
    note(6, '0);
    settings(2'h0, 3'h7, 3'h7);
  endtask

  // Settle time covers the link-to-core synchroniser
  task automatic cmd1(input logic [7:0] b);
    i_host.open_frame();
    i_host.put_bits(b, 8);
    i_host.close_frame();
    repeat (10) @(posedge clock);
    #1;
  endtask

  // Scan outputs follow digit_select one edge later
  task automatic look(input logic [3:0] d);
    @(posedge clock);
    digit_select <= d;
    rom_data     <= {lfsr[2:0], lfsr};
    lfsr = lfsr_next(lfsr);
    @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    // Run needs about 40 us; a hang ends here
    #300_000;
    n_fail++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n       = 1'b0;
    digit_select = 4'h0;
    rom_data     = '0;
    repeat (10) @(posedge clock);
    #1;
    expect_reset();
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    cmd1(8'h57);
    cmd1(8'h67);
    // Every value of each one-byte setting, ignored bits set
    for (int v = 0; v < 8; v++) begin
      cmd1(8'h4c | 8'(v));
      cmd1(8'h58 | 8'(v));
      cmd1(8'h68 | 8'(7 - v));
      settings(2'(v), 3'(v), 3'(7 - v));
    end
    // Nine digits: digit 8 lit, digit 9 blank
    look(4'h8);
    note(6, 35'(16'h0100));
    -> probe;
    look(4'h9);
    note(6, '0);
    -> probe;
    // Trailing bytes, partial byte, stray clocks, unknown opcode
    i_host.open_frame();
    i_host.put_bits(8'h41, 8);
    i_host.put_bits(8'h52, 8);
    i_host.put_bits(8'h42, 5);
    i_host.close_frame();
    i_host.put_bits(8'h43, 8);
    cmd1(8'h7f);
    settings(2'h1, 3'h7, 3'h0);
    cmd1(8'h67);
    // Character codes from digit 14 onward, wrapping past 15
    i_host.open_frame();
    i_host.put_bits(8'h1e, 8);
    for (int i = 0; i < 18; i++) begin
      code[(14 + i) % 16] = lfsr[7:0] | 8'h08;
      lfsr = lfsr_next(lfsr);
      i_host.put_bits(code[(14 + i) % 16], 8);
    end
    i_host.close_frame();
    repeat (10) @(posedge clock);
    for (int d = 0; d < 16; d++) begin
      look(4'(d));
      note(3, 35'(code[d]));
      note(6, 35'(16'h0001 << d));
      note(4, rom_data);
      -> probe;
    end
    // User glyph 3, ignored address bit 3 and column bit 7 set
    i_host.open_frame();
    i_host.put_bits(8'h2b, 8);
    for (int j = 0; j < 5; j++) begin
      cols[j] = lfsr[7:0] | 8'h80;
      lfsr = lfsr_next(lfsr);
      i_host.put_bits(cols[j], 8);
      for (int i = 0; i < 7; i++) begin
        pat[j + 5 * i] = cols[j][i];
      end
    end
    i_host.close_frame();
    i_host.open_frame();
    i_host.put_bits(8'h10, 8);
    i_host.put_bits(8'h03, 8);
    i_host.close_frame();
    // Symbol bits at digit 15, then wrapped to digit 0
    i_host.open_frame();
    i_host.put_bits(8'h3f, 8);
    i_host.put_bits(8'hfd, 8);
    i_host.put_bits(8'h02, 8);
    i_host.close_frame();
    repeat (10) @(posedge clock);
    look(4'h0);
    note(3, 35'(8'h03));
    note(4, pat);
    note(5, 35'(2'h2));
    -> probe;
    look(4'hf);
    note(5, 35'(2'h1));
    -> probe;
    // Reset in mid-run restores settings and blanks the outputs
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    expect_reset();
    @(posedge clock);
    arst_n <= 1'b1;
    cmd1(8'h41);
    settings(2'h1, 3'h7, 3'h7);
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule // vscd_decoder_bench
`default_nettype wire

// ### bench/vscd_host_model.sv
// Host model driving the three-wire serial write link
`default_nettype none
module vscd_host_model (
  // Serial link
  output logic chip_select_low,
  output logic shift_clock_in,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    chip_select_low = 1'b1;
    shift_clock_in  = 1'b0;
    serial_data_in  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock runs only during put_bits, inside a frame or not, 64 ns period
  // Rise lands a fraction off the system clock grid, unrelated in phase
  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in = b[i];
      #32.3 shift_clock_in = 1'b1;
      #31.7 shift_clock_in = 1'b0;
    end
  endtask

  // Select leads the first shift rise by about one link period
  task automatic open_frame();
    #3 chip_select_low = 1'b0;
    #29;
  endtask

  // No pull on data: a released line shows the inverse, not the last bit
  task automatic close_frame();
    #32 chip_select_low = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
endmodule // vscd_host_model
`default_nettype wire

// ### include/vscd_pkg.sv
// Constants and types shared by the serial command decoder
`default_nettype none
package vscd_pkg;
  // Serial framing
  localparam int unsigned BYTE_BITS    = 8;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  // Command byte layout: opcode in the high nibble
  localparam int unsigned OP_MSB       = 7;
  localparam int unsigned OP_LSB       = 4;
  localparam int unsigned ARG_MSB      = 3;
  localparam int unsigned ARG_LSB      = 0;
  localparam logic [3:0]  OP_CHAR      = 4'h1;
  localparam logic [3:0]  OP_GLYPH     = 4'h2;
  localparam logic [3:0]  OP_SYMBOL    = 4'h3;
  localparam logic [3:0]  OP_PORTS     = 4'h4;
  localparam logic [3:0]  OP_DUTY      = 4'h5;
  localparam logic [3:0]  OP_DIGITS    = 4'h6;
  // Memory geometry
  localparam int unsigned DIGITS       = 16;
  localparam int unsigned GLYPHS       = 8;
  localparam int unsigned GLYPH_ROWS   = 7;
  localparam int unsigned GLYPH_COLS   = 5;
  localparam int unsigned GLYPH_DOTS   = 35;
  localparam int unsigned SYMBOL_BITS  = 2;
  localparam int unsigned PORT_BITS    = 2;
  localparam logic [2:0]  LAST_COL     = 3'h4;
  // User glyph codes occupy one page of eight codes
  localparam logic [4:0]  USER_PAGE    = 5'h00;
  // Settings after reset
  localparam logic [1:0]  PORTS_RESET  = 2'h0;
  localparam logic [2:0]  DUTY_RESET   = 3'h7;
  localparam logic [2:0]  DIGITS_RESET = 3'h7;
  localparam logic [4:0]  DIGITS_BASE  = 5'h08;
  localparam logic        LIGHTS_RESET = 1'b0;

  typedef enum logic [1:0] {
    VSCD_IDLE   = 2'b00,
    VSCD_CHAR   = 2'b01,
    VSCD_GLYPH  = 2'b11,
    VSCD_SYMBOL = 2'b10
  } vscd_state_t;

  // One framed byte passed from the link to the core
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } vscd_byte_t;

  // Display settings loaded by one-byte commands
  typedef struct packed {
    logic [1:0] ports;
    logic [2:0] duty;
    logic [2:0] digits;
  } vscd_settings_t;
endpackage
`default_nettype wire

// ### rtl/vscd_decoder.sv
// Serial command decoder of a dot-matrix fluorescent display controller
//
// How it works
// - Reset low initializes all functions
// - Reset zeroes every RAM write pointer
// - Reset leaves RAM contents undefined
// - Reset drives both static ports low
// - Reset sets digit count to sixteen
// - Reset sets duty to eight sixteenths
// - Reset leaves all-lights mode off
// - Reset forces segment and symbol outputs low
// - Chip select high ignores clock and data
// - Bytes arrive LSB first, eight bits
// - Data sampled on shift clock rising edge
// - Internal load strobe per completed byte
// - Chip select fall restarts byte framing
// - Character and symbol RAM address increments after each data byte; glyph address after every fifth
// - Opcode 1: character code write
// - Opcode 2: glyph write, five columns
// - Opcode 3: symbol bits write
// - Opcode 4: load static ports
// - Opcode 5: load three-bit duty
// - Opcode 6: load three-bit digit count
// - Codes pick ROM glyph or user glyph
// - Character address n drives grid n+1
// - Character address wraps fifteen to zero
// - Eight user glyphs of 35 dots
`default_nettype none
module vscd_decoder
  import vscd_pkg::*;
(
  // System clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Serial link
  input  wire logic                  chip_select_low,
  input  wire logic                  shift_clock_in,
  input  wire logic                  serial_data_in,
  // Scan side
  input  wire logic [3:0]            digit_select,
  input  wire logic [GLYPH_DOTS-1:0] fixed_glyph_rom_data,
  output logic      [7:0]            fixed_glyph_rom_code,
  // Driver outputs
  output logic      [GLYPH_DOTS-1:0] dot_segment_outputs,
  output logic      [SYMBOL_BITS-1:0] symbol_segment_outputs,
  output logic      [DIGITS-1:0]     grid_outputs,
  // Settings
  output logic      [PORT_BITS-1:0]  static_output_ports,
  output logic      [2:0]            duty_field,
  output logic      [2:0]            digit_count_field,
  output logic                       all_lights_on
);

  ////////////////////////////////////////////////////////////////////////
  // Link domain: shift register and byte framing

  logic              link_rst_n;
  logic [7:0]        shift_r;
  logic [7:0]        shift_nxt;
  logic [2:0]        bit_cnt_r;
  logic [2:0]        bit_cnt_nxt;
  logic              seen_r;
  logic              seen_nxt;
  logic              byte_done;
  logic              byte_tgl_r;
  logic              byte_tgl_nxt;
  vscd_byte_t        hold_r;
  vscd_byte_t        hold_nxt;

  // Chip select high holds the framing in reset; a partial byte dies here
  assign link_rst_n = arst_n & ~chip_select_low;

  always_comb begin
    shift_nxt    = {serial_data_in, shift_r[7:1]};
    byte_done    = (bit_cnt_r == LAST_BIT);
    bit_cnt_nxt  = bit_cnt_r + 3'h1;
    seen_nxt     = seen_r | byte_done;
    byte_tgl_nxt = byte_tgl_r ^ byte_done;
    hold_nxt     = hold_r;
    if (byte_done) begin
      hold_nxt.first = ~seen_r;
      hold_nxt.data  = shift_nxt;
    end
  end

  always_ff @(posedge shift_clock_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 3'h0;
      seen_r    <= 1'b0;
    end else begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      seen_r    <= seen_nxt;
    end
  end

  // Survives chip select so a last byte still reaches the core
  always_ff @(posedge shift_clock_in or negedge arst_n) begin
    if (!arst_n) begin
      byte_tgl_r <= 1'b0;
      hold_r     <= '0;
    end else begin
      byte_tgl_r <= byte_tgl_nxt;
      hold_r     <= hold_nxt;
    end
  end

  link_done_a: assert property (
    @(posedge shift_clock_in) disable iff (!link_rst_n)
    (bit_cnt_r == LAST_BIT) |=> (byte_tgl_r != $past(byte_tgl_r))
  ) else $error("byte toggle missed after eighth bit");

  link_lsb_a: assert property (
    @(posedge shift_clock_in) disable iff (!link_rst_n)
    (bit_cnt_r == LAST_BIT) |=>
      (hold_r.data[7] == $past(serial_data_in))
  ) else $error("last serial bit not in byte msb");

  ////////////////////////////////////////////////////////////////////////
  // Crossing: toggle through three flops, byte held stable meanwhile

  logic [2:0]        tgl_sync_r;
  logic [2:0]        tgl_sync_nxt;
  logic              byte_evt;
  vscd_byte_t        rx;

  always_comb begin
    tgl_sync_nxt = {tgl_sync_r[1:0], byte_tgl_r};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tgl_sync_r <= 3'h0;
    end else begin
      tgl_sync_r <= tgl_sync_nxt;
    end
  end

  // Hold register is eight link clocks older than the next byte
  assign byte_evt = tgl_sync_r[1] ^ tgl_sync_r[2];
  assign rx       = hold_r;

  ////////////////////////////////////////////////////////////////////////
  // Command decode, pointers and settings

  vscd_state_t       state_r;
  vscd_state_t       state_nxt;
  logic [3:0]        char_addr_r;
  logic [3:0]        char_addr_nxt;
  logic [2:0]        glyph_addr_r;
  logic [2:0]        glyph_addr_nxt;
  logic [2:0]        glyph_col_r;
  logic [2:0]        glyph_col_nxt;
  logic [3:0]        symb_addr_r;
  logic [3:0]        symb_addr_nxt;
  vscd_settings_t    set_r;
  vscd_settings_t    set_nxt;
  logic              char_we;
  logic              glyph_we;
  logic              symb_we;
  logic [3:0]        opcode;
  logic [3:0]        arg;

  assign opcode = rx.data[OP_MSB:OP_LSB];
  assign arg    = rx.data[ARG_MSB:ARG_LSB];

  always_comb begin
    state_nxt      = state_r;
    char_addr_nxt  = char_addr_r;
    glyph_addr_nxt = glyph_addr_r;
    glyph_col_nxt  = glyph_col_r;
    symb_addr_nxt  = symb_addr_r;
    set_nxt        = set_r;
    char_we        = 1'b0;
    glyph_we       = 1'b0;
    symb_we        = 1'b0;
    if (byte_evt && rx.first) begin
      // Unknown opcodes drop any pending write and are ignored
      state_nxt = VSCD_IDLE;
      case (opcode)
        OP_CHAR: begin
          state_nxt     = VSCD_CHAR;
          char_addr_nxt = arg;
        end
        OP_GLYPH: begin
          state_nxt      = VSCD_GLYPH;
          glyph_addr_nxt = arg[2:0];
          glyph_col_nxt  = 3'h0;
        end
        OP_SYMBOL: begin
          state_nxt     = VSCD_SYMBOL;
          symb_addr_nxt = arg;
        end
        OP_PORTS: begin
          set_nxt.ports = arg[PORT_BITS-1:0];
        end
        OP_DUTY: begin
          set_nxt.duty = arg[2:0];
        end
        OP_DIGITS: begin
          set_nxt.digits = arg[2:0];
        end
        default: begin
          state_nxt = VSCD_IDLE;
        end
      endcase
    end else if (byte_evt) begin
      case (state_r)
        VSCD_CHAR: begin
          char_we       = 1'b1;
          char_addr_nxt = char_addr_r + 4'h1;
        end
        VSCD_GLYPH: begin
          glyph_we = 1'b1;
          if (glyph_col_r == LAST_COL) begin
            glyph_col_nxt  = 3'h0;
            glyph_addr_nxt = glyph_addr_r + 3'h1;
          end else begin
            glyph_col_nxt = glyph_col_r + 3'h1;
          end
        end
        VSCD_SYMBOL: begin
          symb_we       = 1'b1;
          symb_addr_nxt = symb_addr_r + 4'h1;
        end
        default: begin
          state_nxt = VSCD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= VSCD_IDLE;
      char_addr_r  <= 4'h0;
      glyph_addr_r <= 3'h0;
      glyph_col_r  <= 3'h0;
      symb_addr_r  <= 4'h0;
      set_r.ports  <= PORTS_RESET;
      set_r.duty   <= DUTY_RESET;
      set_r.digits <= DIGITS_RESET;
    end else begin
      state_r      <= state_nxt;
      char_addr_r  <= char_addr_nxt;
      glyph_addr_r <= glyph_addr_nxt;
      glyph_col_r  <= glyph_col_nxt;
      symb_addr_r  <= symb_addr_nxt;
      set_r        <= set_nxt;
    end
  end

  assign static_output_ports = set_r.ports;
  assign duty_field          = set_r.duty;
  assign digit_count_field   = set_r.digits;
  // No command reaches this mode here, so it stays at its reset value
  assign all_lights_on       = LIGHTS_RESET;

  ports_load_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && rx.first && opcode == OP_PORTS) |=>
      (static_output_ports == $past(rx.data[1:0]))
  ) else $error("static ports not loaded from command");

  duty_load_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && rx.first && opcode == OP_DUTY) |=>
      (duty_field == $past(rx.data[2:0]))
  ) else $error("duty field not loaded from command");

  digits_load_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && rx.first && opcode == OP_DIGITS) |=>
      (digit_count_field == $past(rx.data[2:0]))
  ) else $error("digit count not loaded from command");

  char_cmd_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && rx.first && opcode == OP_CHAR) |=>
      (state_r == VSCD_CHAR && char_addr_r == $past(rx.data[3:0]))
  ) else $error("character command did not set address");

  char_incr_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && !rx.first && state_r == VSCD_CHAR) |=>
      (char_addr_r == 4'($past(char_addr_r) + 4'h1)
       && state_r == VSCD_CHAR)
  ) else $error("character address did not advance");

  glyph_wrap_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && !rx.first && state_r == VSCD_GLYPH
     && glyph_col_r == LAST_COL) |=>
      (glyph_col_r == 3'h0
       && glyph_addr_r == 3'($past(glyph_addr_r) + 3'h1))
  ) else $error("glyph column did not wrap after five");

  symb_incr_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_evt && !rx.first && state_r == VSCD_SYMBOL) |=>
      (symb_addr_r == 4'($past(symb_addr_r) + 4'h1))
  ) else $error("symbol address did not advance");

  ////////////////////////////////////////////////////////////////////////
  // Memories, never reset: contents undefined until written

  logic [7:0]             char_ram  [DIGITS];
  logic [GLYPH_DOTS-1:0]  glyph_ram [GLYPHS];
  logic [SYMBOL_BITS-1:0] symb_ram  [DIGITS];
  logic [GLYPH_DOTS-1:0]  col_mask;
  logic [GLYPH_DOTS-1:0]  col_bits;

  // Column byte j bit i lands on dot j + 5*i
  for (genvar d = 0; d < GLYPH_DOTS; d++) begin : g_dot
    localparam int unsigned COL = d % GLYPH_COLS;
    localparam int unsigned ROW = d / GLYPH_COLS;
    assign col_mask[d] = (glyph_col_r == 3'(COL));
    assign col_bits[d] = rx.data[ROW];
  end

  always_ff @(posedge clock) begin
    if (char_we) begin
      char_ram[char_addr_r] <= rx.data;
    end
    if (glyph_we) begin
      glyph_ram[glyph_addr_r] <= (glyph_ram[glyph_addr_r] & ~col_mask)
                                 | (col_bits & col_mask);
    end
    if (symb_we) begin
      symb_ram[symb_addr_r] <= rx.data[SYMBOL_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern lookup for the digit being scanned

  logic [7:0]             code;
  logic                   user_code;
  logic                   digit_on;
  logic [GLYPH_DOTS-1:0]  dots_nxt;
  logic [GLYPH_DOTS-1:0]  dots_r;
  logic [SYMBOL_BITS-1:0] symb_nxt;
  logic [SYMBOL_BITS-1:0] symb_r;
  logic [DIGITS-1:0]      grid_nxt;
  logic [DIGITS-1:0]      grid_r;

  always_comb begin
    code      = char_ram[digit_select];
    user_code = (code[7:3] == USER_PAGE);
    digit_on  = ({1'b0, digit_select}
                 <= (DIGITS_BASE + {2'h0, set_r.digits}));
    dots_nxt  = user_code ? glyph_ram[code[2:0]]
                          : fixed_glyph_rom_data;
    symb_nxt  = symb_ram[digit_select];
    grid_nxt  = '0;
    if (!digit_on) begin
      dots_nxt = '0;
      symb_nxt = '0;
    end else begin
      grid_nxt[digit_select] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dots_r <= '0;
      symb_r <= '0;
      grid_r <= '0;
    end else begin
      dots_r <= dots_nxt;
      symb_r <= symb_nxt;
      grid_r <= grid_nxt;
    end
  end

  assign fixed_glyph_rom_code   = code;
  assign dot_segment_outputs    = dots_r;
  assign symbol_segment_outputs = symb_r;
  assign grid_outputs           = grid_r;

  grid_onehot_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    $past(arst_n) |->
      (grid_outputs == (({1'b0, $past(digit_select)}
                         <= DIGITS_BASE + {2'h0, $past(digit_count_field)})
                        ? DIGITS'(1) << $past(digit_select) : '0))
  ) else $error("grid output does not follow scanned digit");

endmodule // vscd_decoder
`default_nettype wire
